// file: logic/mdc_pkg.sv
// Package for the memory and display configuration register bank.
// Assumes a 32-bit AHB-Lite register bus and one system clock.
package mdc_pkg;

    // ********************************
    // Register offsets (byte addresses = 4 x index)
    // ********************************
    localparam logic [7:0] IDX_MEM_MAP = 8'h04;
    localparam logic [7:0] IDX_MEM_WIDTH = 8'h05;
    localparam logic [7:0] IDX_ALT_DB = 8'h06;
    localparam logic [7:0] IDX_LCD_CFG = 8'h07;
    localparam logic [9:0] ADDR_MEM_MAP = {IDX_MEM_MAP, 2'b00};
    localparam logic [9:0] ADDR_MEM_WIDTH = {IDX_MEM_WIDTH, 2'b00};
    localparam logic [9:0] ADDR_ALT_DB = {IDX_ALT_DB, 2'b00};
    localparam logic [9:0] ADDR_LCD_CFG = {IDX_LCD_CFG, 2'b00};

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] RST_MEM_MAP = 8'h70;
    localparam logic [7:0] RST_MEM_WIDTH = 8'h20;
    localparam logic [7:0] RST_ALT_DB = 8'h00;
    localparam logic [7:0] RST_LCD_CFG = 8'h00;

    // ********************************
    // Writable bit masks
    // ********************************
    localparam logic [7:0] WMASK_MEM_MAP = 8'hFF;
    localparam logic [7:0] WMASK_MEM_WIDTH = 8'hBB;
    localparam logic [7:0] WMASK_ALT_DB = 8'hFF;
    localparam logic [7:0] WMASK_LCD_CFG = 8'hE0;

    // ********************************
    // Field positions
    // ********************************
    localparam int MAPPING_ENABLE_BIT = 7;
    localparam int BANK_LSB = 4;
    localparam int BOOT_ROM_BIT = 6;
    localparam int ALT_EN_BIT = 7;
    localparam int VIDSPD_LSB = 5;

    // ********************************
    // Memory type codes
    // ********************************
    typedef enum logic [3:0] {
        MT_SRAM_32K = 4'h0, MT_SRAM_128K = 4'h1, MT_SRAM_512K = 4'h2,
        MT_PSRAM_32K = 4'h3, MT_PSRAM_128K = 4'h4, MT_PSRAM_512K = 4'h5,
        MT_DRAM_256KX4 = 4'h6, MT_DRAM_512KX8 = 4'h7, MT_DRAM_1MX4 = 4'h8,
        MT_DRAM_4MX4 = 4'h9, MT_DRAM_256KX16 = 4'hA
    } mdc_mem_type_e;

    localparam logic [3:0] VID_CLK_NORMAL_8 = 4'h4;
    localparam logic [3:0] VID_CLK_SLOW_8 = 4'h5;
    localparam logic [3:0] VID_CLK_FAST_8 = 4'h3;

    // ********************************
    // Decoded configuration carrier
    // ********************************
    typedef struct packed {
        logic mapping_enable;
        logic [3:0] installed_bank_count;
        logic [3:0] memory_type;
        logic memory_type_reserved;
        logic memory_is_dram;
        logic ram_width_select;
        logic boot_rom_width;
        logic option_rom_width;
        logic slow_refresh_select;
        logic self_refresh_select;
        logic suspend_cbr_refresh;
        logic rom_output_enable_n;
        logic early_mapper_cycle;
        logic alt_display_buffer_enable;
        logic [6:0] display_buffer_base;
        logic lcd_controller_disable;
        logic [1:0] video_refresh_speed;
        logic [3:0] video_clocks;
        logic video_speed_reserved;
    } mdc_cfg_s;

endpackage

// file: logic/mdc_field_decode.sv
// Decodes the four raw configuration bytes into named fields.
// Assumes the raw bytes come straight from the register flip-flops.
module mdc_field_decode (
    // Raw register bytes
    input wire logic [7:0] mem_map_raw,
    input wire logic [7:0] mem_width_raw,
    input wire logic [7:0] alt_db_raw,
    input wire logic [7:0] lcd_cfg_raw,
    // Decoded fields
    output mdc_pkg::mdc_cfg_s cfg
);

    // ********************************
    // Video clock count per access
    // ********************************
    function automatic logic [3:0] mdc_vid_clocks(input logic [1:0] spd, input logic wide8);
        logic [3:0] base;
        base = mdc_pkg::VID_CLK_NORMAL_8;
        case (spd)
            2'b01: base = mdc_pkg::VID_CLK_SLOW_8;
            2'b10: base = mdc_pkg::VID_CLK_FAST_8;
            default: base = mdc_pkg::VID_CLK_NORMAL_8;
        endcase
        return wide8 ? base : base + 4'h1;
    endfunction

    always_comb begin
        cfg = '0;
        cfg.mapping_enable = mem_map_raw[mdc_pkg::MAPPING_ENABLE_BIT];
        cfg.installed_bank_count = {1'b0, mem_map_raw[6:4]} + 4'h1;
        cfg.memory_type = mem_map_raw[3:0];
        cfg.memory_type_reserved = mem_map_raw[3:0] > mdc_pkg::MT_DRAM_256KX16;
        cfg.memory_is_dram = (mem_map_raw[3:0] >= mdc_pkg::MT_DRAM_256KX4) &&
            (mem_map_raw[3:0] <= mdc_pkg::MT_DRAM_256KX16);
        cfg.ram_width_select = mem_width_raw[7];
        cfg.boot_rom_width = mem_width_raw[6];
        cfg.option_rom_width = mem_width_raw[5];
        cfg.slow_refresh_select = mem_width_raw[4];
        cfg.self_refresh_select = mem_width_raw[3];
        cfg.suspend_cbr_refresh = ~mem_width_raw[3];
        cfg.rom_output_enable_n = mem_width_raw[1];
        cfg.early_mapper_cycle = mem_width_raw[0];
        cfg.alt_display_buffer_enable = alt_db_raw[mdc_pkg::ALT_EN_BIT];
        cfg.display_buffer_base = alt_db_raw[6:0];
        cfg.lcd_controller_disable = lcd_cfg_raw[7];
        cfg.video_refresh_speed = lcd_cfg_raw[6:5];
        cfg.video_clocks = mdc_vid_clocks(lcd_cfg_raw[6:5], mem_width_raw[7]);
        cfg.video_speed_reserved = &lcd_cfg_raw[6:5];
    end

endmodule

// file: logic/mdc_regs.sv
// Memory and display configuration register bank with an AHB-Lite slave.
// Assumes a single AHB-Lite master, one system clock and a static boot ROM strap.
//
// What this block does
// - Memory control byte one bit 7 enables memory mapping, resets clear.
// - Bits 6:4 give installed RAM banks minus one; reset eight banks.
// - Bits 3:0 pick memory density and type; codes above ten reserved; reset zero.
// - Memory control byte two bit 7 set means 8-bit RAM; reset 16-bit.
// - Bit 6 reads back the sampled boot ROM width strap; read-only.
// - Bit 5 set means 8-bit option ROM; reset value one.
// - Bit 4 selects slow DRAM refresh, only while in suspend and bit 3 is clear.
// - Bit 3 set stops CAS-before-RAS refresh in suspend; DRAM self-refreshes.
// - Bit 1 clear enables ROM output-enable; set disables it; reset enabled.
// - Bit 0 clear delays mapper cycles to T3; set starts them at T2.
// - Alternate buffer enable clear: display refresh base is driven to zero, address bits 21:15 all clear.
// - Enable set: 32 KB window starts at base field, address bits 21:15.
// - LCD byte bits 6:5 set video refresh access clocks; 11 reserved.
module mdc_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Strap pin
    input wire logic boot_rom_width_pin,
    // Suspend state from the power manager
    input wire logic suspend_active,
    // Configuration outputs
    output logic mapping_enable,
    output logic [3:0] installed_bank_count,
    output logic [3:0] memory_type,
    output logic memory_type_reserved,
    output logic ram_width_select,
    output logic boot_rom_width,
    output logic option_rom_width,
    output logic slow_refresh_active,
    output logic cbr_refresh_enable,
    output logic rom_output_enable_n,
    output logic early_mapper_cycle,
    output logic [21:15] display_refresh_base,
    output logic internal_lcd_engine_enable,
    output logic [3:0] video_clocks,
    output logic video_speed_reserved
);

    // ********************************
    // Register state
    // ********************************
    logic [7:0] mem_map_q, mem_map_d;
    logic [7:0] mem_width_q, mem_width_d;
    logic [7:0] alt_db_q, alt_db_d;
    logic [7:0] lcd_cfg_q, lcd_cfg_d;
    logic strap_q, strap_d;
    logic strap_done_q, strap_done_d;

    // ********************************
    // Bus pipeline state
    // ********************************
    logic wr_pend_q, wr_pend_d;
    logic [9:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;

    // ********************************
    // Output state
    // ********************************
    mdc_pkg::mdc_cfg_s cfg;
    mdc_pkg::mdc_cfg_s out_q, out_d;
    logic slow_ref_q, slow_ref_d;
    logic cbr_q, cbr_d;
    logic [6:0] refresh_base_q, refresh_base_d;
    logic lcd_en_q, lcd_en_d;

    logic [7:0] mem_width_view;
    logic addr_phase;

    function automatic logic [7:0] mdc_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic [7:0] mdc_read(input logic [9:0] a, input logic [7:0] m1,
                                            input logic [7:0] m2, input logic [7:0] m3,
                                            input logic [7:0] m4);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            mdc_pkg::ADDR_MEM_MAP: v = m1;
            mdc_pkg::ADDR_MEM_WIDTH: v = m2;
            mdc_pkg::ADDR_ALT_DB: v = m3;
            mdc_pkg::ADDR_LCD_CFG: v = m4;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign addr_phase = hsel && hready && htrans[1];
    assign mem_width_view = {mem_width_q[7], strap_q, mem_width_q[5:0]};

    // ********************************
    // Next-state logic
    // ********************************
    always_comb begin
        mem_map_d = mem_map_q;
        mem_width_d = mem_width_q;
        alt_db_d = alt_db_q;
        lcd_cfg_d = lcd_cfg_q;
        strap_d = strap_q;
        strap_done_d = 1'b1;
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        hrdata_d = hrdata_q;
        if (!strap_done_q) begin
            strap_d = boot_rom_width_pin;
        end
        if (wr_pend_q) begin
            case (wr_addr_q)
                mdc_pkg::ADDR_MEM_MAP: mem_map_d = mdc_merge(mem_map_q, hwdata[7:0],
                                                             mdc_pkg::WMASK_MEM_MAP);
                mdc_pkg::ADDR_MEM_WIDTH: mem_width_d = mdc_merge(mem_width_q, hwdata[7:0],
                                                                 mdc_pkg::WMASK_MEM_WIDTH);
                mdc_pkg::ADDR_ALT_DB: alt_db_d = mdc_merge(alt_db_q, hwdata[7:0],
                                                           mdc_pkg::WMASK_ALT_DB);
                mdc_pkg::ADDR_LCD_CFG: lcd_cfg_d = mdc_merge(lcd_cfg_q, hwdata[7:0],
                                                             mdc_pkg::WMASK_LCD_CFG);
                default: mem_map_d = mem_map_q;
            endcase
        end
        if (addr_phase) begin
            wr_pend_d = hwrite;
            wr_addr_d = haddr[9:0];
            if (!hwrite) begin
                hrdata_d = {24'h000000, mdc_read(haddr[9:0], mem_map_d, {mem_width_d[7], strap_d, mem_width_d[5:0]},
                                                 alt_db_d, lcd_cfg_d)};
                if (haddr[31:10] != 22'h000000) begin
                    hrdata_d = 32'h00000000;
                end
            end
            if (haddr[31:10] != 22'h000000) begin
                wr_pend_d = 1'b0;
            end
        end
    end

    // ********************************
    // Output next values
    // ********************************
    always_comb begin
        out_d = cfg;
        slow_ref_d = cfg.slow_refresh_select && suspend_active && cfg.suspend_cbr_refresh;
        cbr_d = !(suspend_active && cfg.self_refresh_select);
        refresh_base_d = cfg.alt_display_buffer_enable ? cfg.display_buffer_base : 7'h00;
        lcd_en_d = ~cfg.lcd_controller_disable;
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_map_q <= mdc_pkg::RST_MEM_MAP;
            mem_width_q <= mdc_pkg::RST_MEM_WIDTH;
            alt_db_q <= mdc_pkg::RST_ALT_DB;
            lcd_cfg_q <= mdc_pkg::RST_LCD_CFG;
            strap_q <= 1'b0;
            strap_done_q <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 10'h000;
            hrdata_q <= 32'h00000000;
            out_q <= '0;
            slow_ref_q <= 1'b0;
            cbr_q <= 1'b1;
            refresh_base_q <= 7'h00;
            lcd_en_q <= 1'b1;
        end else begin
            mem_map_q <= mem_map_d;
            mem_width_q <= mem_width_d;
            alt_db_q <= alt_db_d;
            lcd_cfg_q <= lcd_cfg_d;
            strap_q <= strap_d;
            strap_done_q <= strap_done_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            out_q <= out_d;
            slow_ref_q <= slow_ref_d;
            cbr_q <= cbr_d;
            refresh_base_q <= refresh_base_d;
            lcd_en_q <= lcd_en_d;
        end
    end

    // ********************************
    // Field decode
    // ********************************
    mdc_field_decode u_decode (
        .mem_map_raw(mem_map_q),
        .mem_width_raw(mem_width_view),
        .alt_db_raw(alt_db_q),
        .lcd_cfg_raw(lcd_cfg_q),
        .cfg(cfg)
    );

    // ********************************
    // Output drive
    // ********************************
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign mapping_enable = out_q.mapping_enable;
    assign installed_bank_count = out_q.installed_bank_count;
    assign memory_type = out_q.memory_type;
    assign memory_type_reserved = out_q.memory_type_reserved;
    assign ram_width_select = out_q.ram_width_select;
    assign boot_rom_width = out_q.boot_rom_width;
    assign option_rom_width = out_q.option_rom_width;
    assign slow_refresh_active = slow_ref_q;
    assign cbr_refresh_enable = cbr_q;
    assign rom_output_enable_n = out_q.rom_output_enable_n;
    assign early_mapper_cycle = out_q.early_mapper_cycle;
    assign display_refresh_base = refresh_base_q;
    assign internal_lcd_engine_enable = lcd_en_q;
    assign video_clocks = out_q.video_clocks;
    assign video_speed_reserved = out_q.video_speed_reserved;

endmodule

// file: tb/mdc_regs_sva.sv
// Checker for the memory and display configuration register bank.
// Assumes binding to mdc_regs and a zero wait-state AHB-Lite master.
module mdc_regs_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Configuration
    input wire logic suspend_active,
    input wire logic mapping_enable,
    input wire logic [3:0] installed_bank_count,
    input wire logic [3:0] memory_type,
    input wire logic memory_type_reserved,
    input wire logic ram_width_select,
    input wire logic boot_rom_width,
    input wire logic option_rom_width,
    input wire logic slow_refresh_active,
    input wire logic cbr_refresh_enable,
    input wire logic rom_output_enable_n,
    input wire logic early_mapper_cycle,
    input wire logic [21:15] display_refresh_base,
    input wire logic internal_lcd_engine_enable
);
    // ****
    // Address phase decode
    // ****
    logic aph;
    logic mapped;
    logic [9:0] a;
    assign a = haddr[9:0];
    assign aph = hsel && hready && htrans[1] && (haddr[31:10] == 22'h0);
    assign mapped = a inside {mdc_pkg::ADDR_MEM_MAP, mdc_pkg::ADDR_MEM_WIDTH, mdc_pkg::ADDR_ALT_DB, mdc_pkg::ADDR_LCD_CFG};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ****
    // Assertions
    // ****
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
    map_en_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_MEM_MAP |=> ##2
        mapping_enable == $past(hwdata[7], 2)) else $error("mapping enable mismatch");
    bank_count_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_MEM_MAP |=> ##2
        installed_bank_count == {1'b0, $past(hwdata[6:4], 2)} + 4'h1) else $error("bank count mismatch");
    mem_type_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_MEM_MAP |=> ##2
        memory_type == $past(hwdata[3:0], 2) && memory_type_reserved == ($past(hwdata[3:0], 2) > 4'hA))
        else $error("memory type mismatch");
    width_bits_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_MEM_WIDTH |=> ##2
        ram_width_select == $past(hwdata[7], 2) && option_rom_width == $past(hwdata[5], 2)
        && rom_output_enable_n == $past(hwdata[1], 2) && early_mapper_cycle == $past(hwdata[0], 2))
        else $error("width bits mismatch");
    boot_strap_a: assert property (aph && !hwrite && a == mdc_pkg::ADDR_MEM_WIDTH |=> hrdata[6] == boot_rom_width)
        else $error("strap readback mismatch");
    slow_gate_a: assert property (slow_refresh_active |-> cbr_refresh_enable && $past(suspend_active))
        else $error("slow refresh outside suspend");
    cbr_gate_a: assert property (!cbr_refresh_enable |-> $past(suspend_active)) else $error("refresh stopped outside suspend");
    disp_base_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_ALT_DB |=> ##2
        display_refresh_base == ($past(hwdata[7], 2) ? $past(hwdata[6:0], 2) : 7'h00))
        else $error("display base mismatch");
    lcd_en_a: assert property (aph && hwrite && a == mdc_pkg::ADDR_LCD_CFG |=> ##2
        internal_lcd_engine_enable == !$past(hwdata[7], 2)) else $error("lcd enable mismatch");
    rsvd_zero_a: assert property (aph && !hwrite && a == mdc_pkg::ADDR_LCD_CFG |=> (hrdata & 32'hFFFFFF1F) == 32'h0)
        else $error("reserved bits not zero");
    unmapped_a: assert property (aph && !hwrite && !mapped |=> hrdata == 32'h0) else $error("unmapped read not zero");

    cover property (aph && hwrite && a == mdc_pkg::ADDR_MEM_MAP);
    cover property (!cbr_refresh_enable);
    cover property (aph && !hwrite && !mapped);
endmodule

// file: tb/mdc_regs_tb.sv
// Testbench for the memory and display configuration register bank.
// Assumes the bench is the only AHB-Lite master and drives all pins except hready, which is tied to hreadyout.
module mdc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] A_MAP = 32'(mdc_pkg::ADDR_MEM_MAP);
    localparam logic [31:0] A_WID = 32'(mdc_pkg::ADDR_MEM_WIDTH);
    localparam logic [31:0] A_ALT = 32'(mdc_pkg::ADDR_ALT_DB);
    localparam logic [31:0] A_LCD = 32'(mdc_pkg::ADDR_LCD_CFG);
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic boot_rom_width_pin = 1'b1;
    logic suspend_active = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, mapping_enable, memory_type_reserved, ram_width_select, boot_rom_width;
    logic option_rom_width, slow_refresh_active, cbr_refresh_enable, rom_output_enable_n, early_mapper_cycle;
    logic internal_lcd_engine_enable, video_speed_reserved;
    logic [3:0] installed_bank_count, memory_type, video_clocks;
    logic [21:15] display_refresh_base;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    mdc_regs u_mdc_regs (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .boot_rom_width_pin(boot_rom_width_pin),
        .suspend_active(suspend_active), .mapping_enable(mapping_enable), .installed_bank_count(installed_bank_count),
        .memory_type(memory_type), .memory_type_reserved(memory_type_reserved), .ram_width_select(ram_width_select),
        .boot_rom_width(boot_rom_width), .option_rom_width(option_rom_width), .slow_refresh_active(slow_refresh_active),
        .cbr_refresh_enable(cbr_refresh_enable), .rom_output_enable_n(rom_output_enable_n),
        .early_mapper_cycle(early_mapper_cycle), .display_refresh_base(display_refresh_base),
        .internal_lcd_engine_enable(internal_lcd_engine_enable), .video_clocks(video_clocks),
        .video_speed_reserved(video_speed_reserved));

    // ****
    // Helpers
    // ****
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        htrans <= 2'h2;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        logic [31:0] d;
        xfer(1'b0, A_MAP, 32'h0, d); chk("map", 32'h70, d);
        xfer(1'b0, A_WID, 32'h0, d); chk("width", 32'h60, d);
        xfer(1'b0, A_ALT, 32'h0, d); chk("alt", 32'h0, d);
        xfer(1'b0, A_LCD, 32'h0, d); chk("lcd", 32'h0, d);
        chk("banks", 32'h8, installed_bank_count);
        chk("lcd_en", 32'h1, internal_lcd_engine_enable);
        chk("vclk", 32'h5, video_clocks);
        chk("opt_rom", 32'h1, option_rom_width);
    endtask

    task automatic t_map();
        logic [7:0] v;
        logic [31:0] d;
        for (int i = 0; i < 16; i++) begin
            v = {i[0], i[2:0] ^ 3'h5, i[3:0]};
            wr(A_MAP, {24'h0, v});
            xfer(1'b0, A_MAP, 32'h0, d); chk("map_rd", {24'h0, v}, d);
            chk("banks", {28'h0, 1'b0, v[6:4]} + 32'h1, installed_bank_count);
            chk("mtype", 32'(i), memory_type); chk("mtype_rsv", 32'(i > 10), memory_type_reserved);
            chk("map_en", 32'(i[0]), mapping_enable);
        end
    endtask

    task automatic t_width();
        logic [7:0] v;
        logic [31:0] d;
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h00 : 8'hFF;
            wr(A_WID, {24'h0, v});
            xfer(1'b0, A_WID, 32'h0, d); chk("wid_rd", {24'h0, (v & 8'hBB) | 8'h40}, d);
            chk("ram_w", 32'(v[7]), ram_width_select); chk("opt_rom", 32'(v[5]), option_rom_width);
            chk("oe_n", 32'(v[1]), rom_output_enable_n); chk("early", 32'(v[0]), early_mapper_cycle);
            chk("boot", 32'h1, boot_rom_width);
        end
    endtask

    task automatic t_refresh();
        logic [31:0] d;
        for (int k = 0; k < 8; k++) begin
            wr(A_WID, {27'h0, k[1:0], 3'h0});
            suspend_active <= k[2];
            xfer(1'b0, A_LCD, 32'h0, d);
            chk("slow", 32'(k[2] & k[1] & !k[0]), slow_refresh_active);
            chk("cbr", 32'(!(k[2] & k[0])), cbr_refresh_enable);
        end
        suspend_active <= 1'b0;
    endtask

    task automatic t_disp();
        logic [31:0] d;
        wr(A_ALT, 32'h2A);
        xfer(1'b0, A_ALT, 32'h0, d); chk("alt_rd", 32'h2A, d); chk("base", 32'h0, display_refresh_base);
        wr(A_ALT, 32'hD5);
        xfer(1'b0, A_ALT, 32'h0, d); chk("alt_rd", 32'hD5, d); chk("base", 32'h55, display_refresh_base);
    endtask

    task automatic t_lcd();
        logic [31:0] d;
        logic [3:0] c;
        for (int k = 0; k < 16; k++) begin
            c = (k[1:0] == 2'h1) ? 4'h5 : (k[1:0] == 2'h2) ? 4'h3 : 4'h4;
            wr(A_WID, {24'h0, k[3], 7'h20});
            wr(A_LCD, {24'h0, k[2], k[1:0], 5'h1F});
            xfer(1'b0, A_LCD, 32'h0, d); chk("lcd_rd", {24'h0, k[2], k[1:0], 5'h00}, d);
            chk("lcd_en", 32'(!k[2]), internal_lcd_engine_enable);
            chk("vclk", 32'(c + 4'(!k[3])), video_clocks); chk("spd_rsv", 32'(k[1:0] == 2'h3), video_speed_reserved);
        end
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        wr(A_MAP, 32'h12);
        wr(32'h20, 32'hFF);
        wr(A_MAP | 32'h400, 32'hFF);
        xfer(1'b0, 32'h20, 32'h0, d); chk("unmapped", 32'h0, d);
        xfer(1'b0, 32'h0C, 32'h0, d); chk("below", 32'h0, d);
        xfer(1'b0, A_MAP, 32'h0, d); chk("map_kept", 32'h12, d);
    endtask

    task automatic t_strap();
        logic [31:0] d;
        boot_rom_width_pin <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        xfer(1'b0, A_MAP, 32'h0, d); chk("map_rst", 32'h70, d);
        xfer(1'b0, A_WID, 32'h0, d); chk("wid_strap", 32'h20, d);
        chk("boot", 32'h0, boot_rom_width);
    endtask

    task automatic conclude();
        if (err_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_map();
        t_width();
        t_refresh();
        t_disp();
        t_lcd();
        t_unmapped();
        t_strap();
        conclude();
    end
endmodule

bind mdc_regs mdc_regs_sva u_mdc_regs_sva (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .suspend_active(suspend_active), .mapping_enable(mapping_enable),
    .installed_bank_count(installed_bank_count), .memory_type(memory_type), .memory_type_reserved(memory_type_reserved),
    .ram_width_select(ram_width_select), .boot_rom_width(boot_rom_width), .option_rom_width(option_rom_width),
    .slow_refresh_active(slow_refresh_active), .cbr_refresh_enable(cbr_refresh_enable),
    .rom_output_enable_n(rom_output_enable_n), .early_mapper_cycle(early_mapper_cycle),
    .display_refresh_base(display_refresh_base), .internal_lcd_engine_enable(internal_lcd_engine_enable));
